// *** logic/csp_pkg.sv ***
// Package of constants and types for the clock strap and power-down control
// What this block does
// RQ1 - Decode latched straps into CPU frequency mode
// RQ2 - Sample straps only while power-good is high
// RQ3 - Afterwards power-good low means power down
// RQ4 - Spread spectrum follows the spread-enable input
// RQ5 - Strap pins become reference and fixed clocks
// RQ6 - Standby reference output toggles while standby power is high
// RQ7 - Management commands switch individual outputs off
// RQ8 - Latched selection holds until next qualification
package csp_pkg;

  localparam int          SEL_W        = 3;
  localparam int          OUT_N        = 4;
  localparam int          OUT_REF1     = 0;
  localparam int          OUT_REF2     = 1;
  localparam int          OUT_FIX      = 2;
  localparam int          OUT_CPU      = 3;
  localparam logic [2:0]  SEL_RESET    = 3'h0;
  localparam logic [3:0]  OFF_RESET    = 4'h0;
  localparam logic [2:0]  SEL_HIZ      = 3'h0;
  localparam logic [2:0]  SEL_XDIV6    = 3'h1;
  localparam logic [2:0]  SEL_180      = 3'h2;
  localparam logic [2:0]  SEL_220      = 3'h3;
  localparam logic [2:0]  SEL_100      = 3'h4;
  localparam logic [2:0]  SEL_133      = 3'h5;
  localparam logic [2:0]  SEL_RSVD     = 3'h6;
  localparam logic [2:0]  SEL_200      = 3'h7;
  // Crystal half periods in ns, rounded up to core_clk cycles, arbitrary model rates
  localparam int          REF_HALF_NS  = 30;
  localparam int          CLK_NS       = 10;
  localparam int          REF_HALF_CYC = (REF_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int          FIX_HALF_NS  = 20;
  localparam int          FIX_HALF_CYC = (FIX_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CNT_W        = 4;

  typedef enum logic [2:0] {
    CSP_CPU_HIZ, CSP_CPU_XDIV6, CSP_CPU_180, CSP_CPU_220,
    CSP_CPU_100, CSP_CPU_133, CSP_CPU_RSVD, CSP_CPU_200
  } csp_cpu_mode_t;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic             valid;
  } csp_strap_t;

  typedef struct packed {
    csp_cpu_mode_t    cpu_mode;
    logic             spread_on;
    logic             powered_down;
    logic             operating;
  } csp_status_t;

endpackage : csp_pkg

// *** logic/csp_div.sv ***
// Toggle divider producing one clock from core_clk
`timescale 1ns/1ps
module csp_div
  import csp_pkg::*;
#(
  parameter int HALF = 2
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic run,
  output logic      clk_out
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             tog_q;
  logic             tog_d;

  always_comb begin
    cnt_d = cnt_q;
    tog_d = tog_q;
    if (!run) begin
      cnt_d = '0;
      tog_d = 1'b0;
    end else if (cnt_q == CNT_W'(HALF - 1)) begin
      cnt_d = '0;
      tog_d = ~tog_q;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      tog_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      tog_q <= tog_d;
    end
  end

  assign clk_out = tog_q;

endmodule : csp_div

// *** logic/csp_ctrl.sv ***
// Strap latch, power-down and output gating for the clock synthesizer
`timescale 1ns/1ps
module csp_ctrl
  import csp_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           reset,
  input  wire logic           clk_en,
  input  wire logic           standby_power,
  input  wire logic           power_good_strobe,
  input  wire logic           spread_en,
  input  wire logic [OUT_N-1:0] mgmt_off,
  input  wire logic           freq_sel_bit0,
  input  wire logic           freq_sel_bit1,
  input  wire logic           freq_sel_bit2,
  output logic                strap0_or_fixed_clk_out,
  output logic                strap0_oe_n,
  output logic                strap1_or_ref_out,
  output logic                strap1_oe_n,
  output logic                strap2_or_ref_out,
  output logic                strap2_oe_n,
  output logic                standby_ref_out,
  output logic                cpu_clk_en,
  output logic                cpu_hiz,
  output csp_status_t         status
);

  csp_strap_t            strap_q;
  csp_strap_t            strap_d;
  logic [OUT_N-1:0]      off_q;
  logic [OUT_N-1:0]      off_d;
  logic                  pd_q;
  logic                  pd_d;
  logic                  spread_q;
  logic                  spread_d;
  logic                  ref_clk;
  logic                  fix_clk;
  logic [OUT_N-1:0]      out_on;
  csp_cpu_mode_t         mode;

  always_comb begin
    strap_d  = strap_q;
    off_d    = mgmt_off;                                           // RQ7
    spread_d = spread_en;                                          // RQ4
    pd_d     = strap_q.valid && !power_good_strobe;                // RQ3
    // Straps sampled once per qualification, then held
    if (!strap_q.valid && power_good_strobe) begin                 // RQ2
      strap_d.sel   = {freq_sel_bit2, freq_sel_bit1, freq_sel_bit0}; // RQ8
      strap_d.valid = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      strap_q  <= '{sel: SEL_RESET, valid: 1'b0};
      off_q    <= OFF_RESET;
      pd_q     <= 1'b0;
      spread_q <= 1'b0;
    end else if (clk_en) begin
      strap_q  <= strap_d;
      off_q    <= off_d;
      pd_q     <= pd_d;
      spread_q <= spread_d;
    end
  end

  // Power-down held as a level; strap reused only after power-on reset
  always_comb begin
    case (strap_q.sel)                                             // RQ1
      SEL_HIZ:   mode = CSP_CPU_HIZ;
      SEL_XDIV6: mode = CSP_CPU_XDIV6;
      SEL_180:   mode = CSP_CPU_180;
      SEL_220:   mode = CSP_CPU_220;
      SEL_100:   mode = CSP_CPU_100;
      SEL_133:   mode = CSP_CPU_133;
      SEL_RSVD:  mode = CSP_CPU_RSVD;
      SEL_200:   mode = CSP_CPU_200;
      default:   mode = CSP_CPU_HIZ;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < OUT_N; gi++) begin : g_on
      assign out_on[gi] = strap_q.valid && !pd_q && !off_q[gi];    // RQ7
    end
  endgenerate

  csp_div #(.HALF(REF_HALF_CYC)) u_ref (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .run      (standby_power),                                     // RQ6
    .clk_out  (ref_clk)
  );

  csp_div #(.HALF(FIX_HALF_CYC)) u_fix (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .run      (strap_q.valid),
    .clk_out  (fix_clk)
  );

  // Pins stay inputs until latched so straps are not overdriven
  assign strap1_oe_n             = !strap_q.valid;                 // RQ5
  assign strap2_oe_n             = !strap_q.valid;                 // RQ5
  assign strap0_oe_n             = !strap_q.valid;                 // RQ5
  assign strap1_or_ref_out       = ref_clk && out_on[OUT_REF1];    // RQ5
  assign strap2_or_ref_out       = ref_clk && out_on[OUT_REF2];    // RQ5
  assign strap0_or_fixed_clk_out = fix_clk && out_on[OUT_FIX];     // RQ5
  assign standby_ref_out         = ref_clk;                        // RQ6
  assign cpu_hiz                 = strap_q.valid && (mode == CSP_CPU_HIZ);
  assign cpu_clk_en              = out_on[OUT_CPU] && (mode != CSP_CPU_HIZ) && (mode != CSP_CPU_RSVD);
  assign status                  = '{cpu_mode: mode, spread_on: spread_q, powered_down: pd_q,
                                     operating: strap_q.valid};

endmodule : csp_ctrl

// *** sim/csp_board.sv ***
// Board straps and power controller model
`timescale 1ns/1ps
module csp_board (
  input  wire logic       core_clk,
  input  wire logic [2:0] sel,
  input  wire logic       pg_req,
  input  wire logic [2:0] oe_n,
  input  wire logic [2:0] dout,
  output logic [2:0]      pin,
  output logic            power_good_strobe
);
  logic [2:0] strap_q;
  always_ff @(posedge core_clk) strap_q <= sel;
  always_ff @(posedge core_clk) power_good_strobe <= pg_req;
  // Device owns the pin once its enable is low
  assign pin = (oe_n & strap_q) | (~oe_n & dout);
endmodule : csp_board

// *** sim/csp_ctrl_chk.sv ***
// Port assertions for csp_ctrl
`timescale 1ns/1ps
module csp_ctrl_chk
  import csp_pkg::*;
(
  input wire logic core_clk, reset, clk_en, standby_power, power_good_strobe, spread_en,
  input wire logic [OUT_N-1:0] mgmt_off,
  input wire logic strap0_oe_n, strap1_oe_n, standby_ref_out, cpu_clk_en, cpu_hiz,
  input wire csp_status_t status
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_take; clk_en && !status.operating && power_good_strobe; endsequence
  a_spread_on: assert property (clk_en && spread_en |=> status.spread_on) else $error("spread");
  a_spread_off: assert property (clk_en && !spread_en |=> !status.spread_on) else $error("spread");
  a_strap_take: assert property (s_take |=> status.operating && !strap1_oe_n) else $error("latch");
  a_pins_idle: assert property (!status.operating |-> strap0_oe_n) else $error("oe");
  a_mode_hold: assert property (status.operating |=> $stable(status.cpu_mode)) else $error("mode");
  a_pd_enter: assert property (clk_en && status.operating && !power_good_strobe
    |=> status.powered_down && !cpu_clk_en) else $error("pd");
  a_hiz_map: assert property (cpu_hiz == (status.operating && status.cpu_mode == CSP_CPU_HIZ)) else $error("hiz");
  a_ref_runs: assert property ((standby_power && clk_en) [*8] |-> standby_ref_out != $past(standby_ref_out, 3))
    else $error("ref");
  a_cpu_off: assert property (clk_en && mgmt_off[OUT_CPU] |=> !cpu_clk_en) else $error("off");
endmodule : csp_ctrl_chk

// *** sim/csp_ctrl_bench.sv ***
// Self-checking bench for csp_ctrl
`timescale 1ns/1ps
module clock_strap_and_powerdown_ctrl_bench;
  import csp_pkg::*;
  logic core_clk = 0, reset = 1, clk_en = 1, standby_power = 1, spread_en = 0, pg_req = 0;
  logic [OUT_N-1:0] mgmt_off = '0;
  logic [2:0] sel = '0;
  wire logic freq_sel_bit0, freq_sel_bit1, freq_sel_bit2, power_good_strobe;
  logic strap0_or_fixed_clk_out, strap1_or_ref_out, strap2_or_ref_out, strap0_oe_n, strap1_oe_n, strap2_oe_n;
  logic standby_ref_out, cpu_clk_en, cpu_hiz;
  csp_status_t status;
  int n_mismatch = 0, compares = 0, c[4];
  csp_board brd (.core_clk, .sel, .pg_req, .power_good_strobe, .oe_n({strap2_oe_n, strap1_oe_n, strap0_oe_n}),
    .dout({strap2_or_ref_out, strap1_or_ref_out, strap0_or_fixed_clk_out}),
    .pin({freq_sel_bit2, freq_sel_bit1, freq_sel_bit0}));
  csp_ctrl uut (.core_clk, .reset, .clk_en, .standby_power, .power_good_strobe, .spread_en, .mgmt_off,
    .freq_sel_bit0, .freq_sel_bit1, .freq_sel_bit2, .strap0_or_fixed_clk_out, .strap0_oe_n, .strap1_or_ref_out,
    .strap1_oe_n, .strap2_or_ref_out, .strap2_oe_n, .standby_ref_out, .cpu_clk_en, .cpu_hiz, .status);
  initial forever #5 core_clk = ~core_clk;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Edge counts over a fixed window, phase of each divider is irrelevant
  task automatic watch();
    logic [3:0] p;
    logic [3:0] v;
    c = '{0, 0, 0, 0};
    // Start on a settled level, never on the launching edge
    @(negedge core_clk);
    p = {strap2_or_ref_out, standby_ref_out, strap1_or_ref_out, strap0_or_fixed_clk_out};
    repeat (60) begin
      @(negedge core_clk);
      v = {strap2_or_ref_out, standby_ref_out, strap1_or_ref_out, strap0_or_fixed_clk_out};
      for (int k = 0; k < 4; k++) c[k] += int'(v[k] !== p[k]);
      p = v;
    end
  endtask : watch
  task automatic conclude();
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  initial begin
    void'($urandom(62912));
    // Only reset requalifies the straps, so each code gets its own reset
    for (int s = 0; s < 8; s++) begin
      @(posedge core_clk);
      reset <= 1;
      pg_req <= 0;
      standby_power <= 1;
      sel <= 3'(s);
      mgmt_off <= 4'($urandom);
      spread_en <= 1'($urandom);
      repeat (12) @(posedge core_clk);
      reset <= 0;
      @(negedge core_clk);
      chk("oe_idle", 8'h07, 8'({strap2_oe_n, strap1_oe_n, strap0_oe_n}));
      @(posedge core_clk);
      pg_req <= 1;
      for (int i = 0; i < 9 && status.operating !== 1'b1; i++) @(negedge core_clk);
      if (status.operating !== 1'b1) begin
        n_mismatch++;
        break;
      end
      chk("mode", 8'(s), 8'(status.cpu_mode));
      chk("hiz", 8'(s == 0), 8'(cpu_hiz));
      chk("spread", 8'(spread_en), 8'(status.spread_on));
      chk("oe_run", 8'h00, 8'({strap2_oe_n, strap1_oe_n, strap0_oe_n}));
      @(posedge core_clk);
      sel <= ~3'(s);
      watch();
      chk("cpu", 8'(s != 0 && s != 6 && !mgmt_off[3]), 8'(cpu_clk_en));
      chk("fix", 8'(mgmt_off[2] ? 0 : 60 / FIX_HALF_CYC), 8'(c[0]));
      chk("ref", 8'(mgmt_off[0] ? 0 : 60 / REF_HALF_CYC), 8'(c[1]));
      chk("ref2", 8'(mgmt_off[1] ? 0 : 60 / REF_HALF_CYC), 8'(c[3]));
      chk("hold", 8'(s), 8'(status.cpu_mode));
      // Clock enable low must freeze every divider
      @(posedge core_clk);
      clk_en <= 0;
      watch();
      chk("freeze", 8'h00, 8'(c[0] + c[1] + c[2] + c[3]));
      @(posedge core_clk);
      clk_en <= 1;
      pg_req <= 0;
      repeat (3) @(negedge core_clk);
      chk("pd", 8'h01, 8'(status.powered_down));
      chk("cpu_pd", 8'h00, 8'(cpu_clk_en));
      watch();
      chk("fix_pd", 8'h00, 8'(c[0]));
      chk("run", 8'(60 / REF_HALF_CYC), 8'(c[2]));
      chk("ref_pd", 8'h00, 8'(c[1] + c[3]));
      // Power good back high leaves power down but keeps the latched code
      @(posedge core_clk);
      pg_req <= 1;
      standby_power <= 0;
      repeat (3) @(negedge core_clk);
      chk("pd_exit", 8'h00, 8'(status.powered_down));
      chk("requal", 8'(s), 8'(status.cpu_mode));
      watch();
      chk("fix_back", 8'(mgmt_off[2] ? 0 : 60 / FIX_HALF_CYC), 8'(c[0]));
      chk("stby_off", 8'h00, 8'(c[2]));
    end
    conclude();
  end
endmodule : clock_strap_and_powerdown_ctrl_bench
bind csp_ctrl csp_ctrl_chk chk_i (.core_clk, .reset, .clk_en, .standby_power, .power_good_strobe, .spread_en,
  .mgmt_off, .strap0_oe_n, .strap1_oe_n, .standby_ref_out, .cpu_clk_en, .cpu_hiz, .status);
